// *** src/rsi_regs.sv ***
// Radio status, identification and regulator control registers behind an APB slave.
`timescale 1ns/1ps
module rsi_regs #(
    parameter logic [7:0] REVISION_CODE = 8'h5a,
    parameter logic [7:0] PART_ID_CODE  = 8'ha7
) (
    input  wire logic                       clk_sys,
    input  wire logic                       reset_n,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [rsi_pkg::ADDR_W-1:0] paddr,
    input  wire logic [rsi_pkg::DATA_W-1:0] pwdata,
    output logic      [rsi_pkg::DATA_W-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       tx_active_in,
    input  wire logic                       sfd_in,
    input  wire logic                       cca_in,
    input  wire logic [7:0]                 rx_byte_count,
    input  wire logic                       addr_filter_enable,
    input  wire logic                       filter_pass,
    input  wire logic                       frame_complete,
    input  wire logic                       ack_frame_rx,
    input  wire logic [1:0]                 power_mode,
    output logic                            analog_reg_enable,
    output logic                            digital_reg_enable,
    output logic                            radio_irq_pending
);
    // Registers carry no power-mode term: contents survive regulator shutdown.

    rsi_pwr_if pwr ();

    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_c;
    logic [2:0] pins;
    logic [2:0] next_pins;

    logic [rsi_pkg::THR_W-1:0] rx_threshold_level;
    logic [rsi_pkg::THR_W-1:0] next_rx_threshold_level;
    logic                      ack_irq_enable;
    logic                      next_ack_irq_enable;
    logic                      analog_reg_powerdown;
    logic                      next_analog_reg_powerdown;
    logic [1:0]                delay_sel;
    logic [1:0]                next_delay_sel;
    logic [1:0]                radio_irq_flags;
    logic [1:0]                next_radio_irq_flags;
    logic                      filter_passed;
    logic                      next_filter_passed;
    logic                      frame_done;
    logic                      next_frame_done;
    logic                      rx_threshold_flag;
    logic                      next_rx_threshold_flag;

    logic [rsi_pkg::DATA_W-1:0] next_prdata;
    logic                       next_pready;
    logic                       next_pslverr;
    logic                       next_analog_reg_enable;
    logic                       next_digital_reg_enable;
    logic                       next_radio_irq_pending;
    logic                       access;
    logic                       wr;
    logic                       hit;
    logic [7:0]                 rdata8;
    logic [7:0]                 status;

    function automatic logic [rsi_pkg::ADDR_W-1:0] addr_of(input logic [15:0] idx);
        addr_of = {idx, 2'b00};
    endfunction

    // A change on an asynchronous input counts only once the second and third stages agree.
    always_comb begin
        next_pins = pins;
        for (int i = 0; i < 3; i++) begin
            if (sync_b[i] == sync_c[i]) begin
                next_pins[i] = sync_c[i];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
            sync_c <= 3'h0;
            pins   <= 3'h0;
        end else begin
            sync_a <= {tx_active_in, sfd_in, cca_in};
            sync_b <= sync_a;
            sync_c <= sync_b;
            pins   <= next_pins;
        end
    end

    always_comb begin
        status                       = 8'h00;
        status[rsi_pkg::STAT_TX]     = pins[2];
        status[rsi_pkg::STAT_RXD]    = (rx_byte_count != 8'h00);
        status[rsi_pkg::STAT_THR]    = rx_threshold_flag;
        status[rsi_pkg::STAT_SFD]    = pins[1];
        status[rsi_pkg::STAT_CCA]    = pins[0];
    end

    always_comb begin
        access = psel && penable && !pready;
        wr     = access && pwrite;
        hit    = 1'b1;
        rdata8 = 8'h00;
        case (paddr)
            addr_of(rsi_pkg::IDX_REVISION): rdata8 = REVISION_CODE;
            addr_of(rsi_pkg::IDX_PART_ID):  rdata8 = PART_ID_CODE;
            addr_of(rsi_pkg::IDX_STATUS):   rdata8 = status;
            addr_of(rsi_pkg::IDX_IRQ_SRC):  rdata8 = {7'h00, ack_irq_enable};
            addr_of(rsi_pkg::IDX_IO_CFG0):  rdata8 = {1'b0, rx_threshold_level};
            addr_of(rsi_pkg::IDX_PWR_CTRL): begin
                rdata8[rsi_pkg::PWR_PD]      = analog_reg_powerdown;
                rdata8[rsi_pkg::PWR_UP_STAT] = pwr.reg_on;
                rdata8[rsi_pkg::PWR_DLY_LSB +: rsi_pkg::PWR_DLY_W] = delay_sel;
            end
            addr_of(rsi_pkg::IDX_IRQ_FLAGS): rdata8 = {6'h00, radio_irq_flags};
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        next_rx_threshold_level   = rx_threshold_level;
        next_ack_irq_enable       = ack_irq_enable;
        next_analog_reg_powerdown = analog_reg_powerdown;
        next_delay_sel            = delay_sel;
        next_radio_irq_flags      = radio_irq_flags;
        if (wr) begin
            case (paddr)
                addr_of(rsi_pkg::IDX_IO_CFG0): begin
                    next_rx_threshold_level = pwdata[rsi_pkg::THR_W-1:0];
                end
                addr_of(rsi_pkg::IDX_IRQ_SRC): begin
                    next_ack_irq_enable = pwdata[rsi_pkg::SRC_ACK_EN];
                end
                addr_of(rsi_pkg::IDX_PWR_CTRL): begin
                    next_analog_reg_powerdown = pwdata[rsi_pkg::PWR_PD];
                    next_delay_sel = pwdata[rsi_pkg::PWR_DLY_LSB +: rsi_pkg::PWR_DLY_W];
                end
                addr_of(rsi_pkg::IDX_IRQ_FLAGS): begin
                    next_radio_irq_flags = radio_irq_flags & ~pwdata[1:0];
                end
                default: next_radio_irq_flags = radio_irq_flags;
            endcase
        end
        // Hardware sets after the software clear so an event in the clear cycle is kept.
        if (pwr.ready_pulse) begin
            next_radio_irq_flags[rsi_pkg::FLAG_READY] = 1'b1;
        end
        if (ack_frame_rx && ack_irq_enable) begin
            next_radio_irq_flags[rsi_pkg::FLAG_ACK] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rx_threshold_level   <= rsi_pkg::THR_RESET;
            ack_irq_enable       <= 1'b0;
            analog_reg_powerdown <= rsi_pkg::PD_RESET;
            delay_sel            <= rsi_pkg::DLY_RESET;
            radio_irq_flags      <= 2'h0;
        end else begin
            rx_threshold_level   <= next_rx_threshold_level;
            ack_irq_enable       <= next_ack_irq_enable;
            analog_reg_powerdown <= next_analog_reg_powerdown;
            delay_sel            <= next_delay_sel;
            radio_irq_flags      <= next_radio_irq_flags;
        end
    end

    // Frame qualifiers last until the queue drains, since the flag must not drop mid-frame.
    always_comb begin
        next_filter_passed = filter_passed || filter_pass;
        next_frame_done    = frame_done || frame_complete;
        if (rx_byte_count == 8'h00 && !filter_pass && !frame_complete) begin
            next_filter_passed = 1'b0;
            next_frame_done    = 1'b0;
        end
        next_rx_threshold_flag =
            ((rx_byte_count > {1'b0, rx_threshold_level})
             && (!addr_filter_enable || filter_passed))
            || (frame_done && rx_byte_count != 8'h00);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            filter_passed     <= 1'b0;
            frame_done        <= 1'b0;
            rx_threshold_flag <= 1'b0;
        end else begin
            filter_passed     <= next_filter_passed;
            frame_done        <= next_frame_done;
            rx_threshold_flag <= next_rx_threshold_flag;
        end
    end

    assign pwr.powerdown = analog_reg_powerdown;
    assign pwr.delay_sel = delay_sel;

    rsi_pwr_seq u_pwr_seq (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .pwr     (pwr.seq)
    );

    always_comb begin
        next_pready             = access;
        next_pslverr            = access && !hit;
        next_prdata             = '0;
        if (access && !pwrite) begin
            next_prdata[7:0] = rdata8;
        end
        next_analog_reg_enable  = pwr.reg_on;
        next_digital_reg_enable = !(power_mode == rsi_pkg::PMODE_TWO ||
                                    power_mode == rsi_pkg::PMODE_THREE);
        next_radio_irq_pending  = |next_radio_irq_flags;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prdata             <= '0;
            pready             <= 1'b0;
            pslverr            <= 1'b0;
            analog_reg_enable  <= 1'b0;
            digital_reg_enable <= 1'b1;
            radio_irq_pending  <= 1'b0;
        end else begin
            prdata             <= next_prdata;
            pready             <= next_pready;
            pslverr            <= next_pslverr;
            analog_reg_enable  <= next_analog_reg_enable;
            digital_reg_enable <= next_digital_reg_enable;
            radio_irq_pending  <= next_radio_irq_pending;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence rd_setup(logic [15:0] idx);
        psel && !penable && !pwrite && paddr == addr_of(idx);
    endsequence

    rev_read_a: assert property (
        rd_setup(rsi_pkg::IDX_REVISION) ##1 penable [*2] |-> prdata[7:0] == REVISION_CODE)
        else $error("Revision read returned wrong value.");
    id_read_a: assert property (
        rd_setup(rsi_pkg::IDX_PART_ID) ##1 penable [*2] |-> prdata == {24'h0, PART_ID_CODE})
        else $error("Identification read returned wrong value.");
    tx_bit_a: assert property (
        tx_active_in [*5] |-> status[rsi_pkg::STAT_TX])
        else $error("Transmit bit does not follow transmitter.");
    rxd_bit_a: assert property (
        status[rsi_pkg::STAT_RXD] == (rx_byte_count != 8'h00))
        else $error("Data available bit wrong.");
    thr_empty_a: assert property (
        rx_byte_count <= {1'b0, rx_threshold_level} && !frame_done && !frame_complete
        |=> !rx_threshold_flag)
        else $error("Threshold flag set at or below level.");
    thr_filter_a: assert property (
        addr_filter_enable && !filter_passed && !frame_done |=> !rx_threshold_flag)
        else $error("Threshold flag set before filter pass.");
    sfd_bit_a: assert property (
        !sfd_in [*5] |-> !status[rsi_pkg::STAT_SFD])
        else $error("Delimiter bit does not follow delimiter.");
    ack_flag_a: assert property (
        ack_frame_rx && !ack_irq_enable && !radio_irq_flags[rsi_pkg::FLAG_ACK]
        |=> !radio_irq_flags[rsi_pkg::FLAG_ACK] || $past(wr))
        else $error("Acknowledge flag set while disabled.");
    status_rsvd_a: assert property (
        rd_setup(rsi_pkg::IDX_STATUS) ##1 penable [*2] |-> prdata[7:5] == 3'h0)
        else $error("Reserved status bits nonzero.");
    ready_flag_a: assert property (
        pwr.ready_pulse |=> radio_irq_flags[rsi_pkg::FLAG_READY])
        else $error("Regulator-ready flag not set.");
    deep_mode_a: assert property (
        power_mode[1] |=> !digital_reg_enable)
        else $error("Digital regulator on in deep power mode.");
    ack_set_a: assert property (
        ack_frame_rx && ack_irq_enable |=> radio_irq_flags[rsi_pkg::FLAG_ACK])
        else $error("Acknowledge flag not set while enabled.");
    pwr_stat_a: assert property (
        rd_setup(rsi_pkg::IDX_PWR_CTRL) ##1 penable [*2]
        |-> prdata[rsi_pkg::PWR_UP_STAT] == $past(pwr.reg_on))
        else $error("Power-up status read wrong.");
    src_rsvd_a: assert property (
        rd_setup(rsi_pkg::IDX_IRQ_SRC) ##1 penable [*2] |-> prdata[7:1] == 7'h00)
        else $error("Reserved source bits nonzero.");
endmodule // rsi_regs

// *** src/rsi_pkg.sv ***
// Package with the register map, field layout, reset values and timing of the radio status block.
// Function
// - Read-only 8-bit revision register encodes the die revision; value may change.
// - Read-only 8-bit identification register always returns one fixed code.
// - Status bit 4 is 1 while transmitting, 0 when idle.
// - Status bit 3 is 1 while the receive queue holds a byte.
// - Status bit 2 is 1 when queued bytes exceed the threshold level.
// - With filtering on, threshold flag waits for filter pass; complete frame sets it.
// - Status bit 1 follows the start-of-frame delimiter state.
// - Interrupt-source bit 0 lets acknowledge frames set the radio interrupt flag.
// - Reserved bits of interrupt-source and status registers read as zero.
// - Writing 1 to the analog power-down bit disables the analog regulator.
// - After power-down clears, wait the programmed delay before enabling the regulator.
// - Delay expiry sets the regulator-ready interrupt flag.
// - A pollable power register bit shows the delayed power-on has completed.
// - Digital regulator is off in the two deepest power modes.
// - Registers keep their contents while regulators are off.
// - Threshold level is a 7-bit programmable field, reset value 0x40.
package rsi_pkg;
    localparam int          ADDR_W        = 18;
    localparam int          DATA_W        = 32;
    localparam logic [15:0] IDX_REVISION  = 16'hdf60;
    localparam logic [15:0] IDX_PART_ID   = 16'hdf61;
    localparam logic [15:0] IDX_STATUS    = 16'hdf62;
    localparam logic [15:0] IDX_IRQ_SRC   = 16'hdf64;
    localparam logic [15:0] IDX_IO_CFG0   = 16'hdf4f;
    localparam logic [15:0] IDX_PWR_CTRL  = 16'hdf68;
    localparam logic [15:0] IDX_IRQ_FLAGS = 16'hdf69;
    localparam int          STAT_TX       = 4;
    localparam int          STAT_RXD      = 3;
    localparam int          STAT_THR      = 2;
    localparam int          STAT_SFD      = 1;
    localparam int          STAT_CCA      = 0;
    localparam int          SRC_ACK_EN    = 0;
    localparam int          PWR_PD        = 3;
    localparam int          PWR_UP_STAT   = 2;
    localparam int          PWR_DLY_LSB   = 0;
    localparam int          PWR_DLY_W     = 2;
    localparam int          FLAG_READY    = 0;
    localparam int          FLAG_ACK      = 1;
    localparam int          THR_W         = 7;
    localparam logic [6:0]  THR_RESET     = 7'h40;
    localparam logic        PD_RESET      = 1'b1;
    localparam logic [1:0]  DLY_RESET     = 2'h3;
    localparam logic [1:0]  PMODE_TWO     = 2'h2;
    localparam logic [1:0]  PMODE_THREE   = 2'h3;
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          PWR_UNIT_NS   = 1000;
    localparam int          PWR_UNIT_CYC  = (PWR_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          PWR_CNT_W     = 10;
endpackage

// *** src/rsi_pwr_if.sv ***
// Interface between the register bank and the analog regulator power-up sequencer.
`timescale 1ns/1ps
interface rsi_pwr_if;
    logic       powerdown;
    logic [1:0] delay_sel;
    logic       reg_on;
    logic       ready_pulse;
    modport ctrl (output powerdown, output delay_sel, input reg_on, input ready_pulse);
    modport seq (input powerdown, input delay_sel, output reg_on, output ready_pulse);
endinterface

// *** src/rsi_pwr_seq.sv ***
// Analog regulator power-up sequencer with a programmable delay.
`timescale 1ns/1ps
module rsi_pwr_seq (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    rsi_pwr_if.seq    pwr
);
    typedef enum logic [1:0] {SEQ_OFF, SEQ_WAIT, SEQ_ON} rsi_seq_type;

    rsi_seq_type                  state;
    rsi_seq_type                  next_state;
    logic [rsi_pkg::PWR_CNT_W-1:0] count;
    logic [rsi_pkg::PWR_CNT_W-1:0] next_count;
    logic                          next_pulse;
    logic                          pulse;
    logic [rsi_pkg::PWR_CNT_W:0]   wait_cnt;
    logic [rsi_pkg::PWR_CNT_W:0]   next_wait_cnt;

    function automatic logic [rsi_pkg::PWR_CNT_W-1:0] delay_cycles(input logic [1:0] sel);
        delay_cycles = rsi_pkg::PWR_CNT_W'(({30'h0, sel} + 32'h1) * rsi_pkg::PWR_UNIT_CYC);
    endfunction

    always_comb begin
        next_state = state;
        next_count = count;
        next_pulse = 1'b0;
        next_wait_cnt = (pwr.powerdown || pwr.reg_on) ? '0 : wait_cnt + 1'b1;
        case (state)
            SEQ_OFF: begin
                if (!pwr.powerdown) begin
                    next_state = SEQ_WAIT;
                    next_count = delay_cycles(pwr.delay_sel) - 1'b1;
                end
            end
            SEQ_WAIT: begin
                if (pwr.powerdown) begin
                    next_state = SEQ_OFF;
                end else if (count == '0) begin
                    next_state = SEQ_ON;
                    next_pulse = 1'b1;
                end else begin
                    next_count = count - 1'b1;
                end
            end
            SEQ_ON: begin
                if (pwr.powerdown) begin
                    next_state = SEQ_OFF;
                end
            end
            default: next_state = SEQ_OFF;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= SEQ_OFF;
            count <= '0;
            pulse <= 1'b0;
            wait_cnt <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
            pulse <= next_pulse;
            wait_cnt <= next_wait_cnt;
        end
    end

    assign pwr.reg_on      = (state == SEQ_ON);
    assign pwr.ready_pulse = pulse;

    pd_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pwr.powerdown |=> !pwr.reg_on)
        else $error("Regulator on while power-down is set.");
    delay_end_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !pwr.powerdown && !pwr.reg_on |-> wait_cnt <= 4 * rsi_pkg::PWR_UNIT_CYC)
        else $error("Regulator power-on delay too long.");
    delay_min_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(pwr.reg_on) |-> wait_cnt > rsi_pkg::PWR_UNIT_CYC)
        else $error("Regulator power-on delay too short.");
    ready_pulse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(pwr.reg_on) |-> pwr.ready_pulse)
        else $error("Ready pulse missing at power-on.");
endmodule // rsi_pwr_seq

// *** tb/test_radio_status_id_regs.sv ***
// Self-checking testbench for the radio status and identification register bank.
`timescale 1ns/1ps
module test_radio_status_id_regs;
    // Both codes are arbitrary values, chosen only to differ from each other.
    localparam logic [7:0] REV_CODE = 8'h3c;
    localparam logic [7:0] PID_CODE = 8'hc3;

    logic                           clk_sys;
    logic                           reset_n;
    logic                           psel;
    logic                           penable;
    logic                           pwrite;
    logic [rsi_pkg::ADDR_W-1:0]     paddr;
    logic [rsi_pkg::DATA_W-1:0]     pwdata;
    logic [rsi_pkg::DATA_W-1:0]     prdata;
    logic                           pready;
    logic                           pslverr;
    logic                           tx_active_in;
    logic                           sfd_in;
    logic                           cca_in;
    logic [7:0]                     rx_byte_count;
    logic                           addr_filter_enable;
    logic                           filter_pass;
    logic                           frame_complete;
    logic                           ack_frame_rx;
    logic [1:0]                     power_mode;
    logic                           analog_reg_enable;
    logic                           digital_reg_enable;
    logic                           radio_irq_pending;
    int                             mismatches;
    int                             comparisons;
    logic [31:0]                    seed;
    logic [31:0]                    r;
    logic [7:0]                     d;
    logic                           e;
    int                             m_lvl;
    int                             m_cnt;
    int                             n;

    rsi_regs #(.REVISION_CODE(REV_CODE), .PART_ID_CODE(PID_CODE)) dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_active_in(tx_active_in),
        .sfd_in(sfd_in), .cca_in(cca_in), .rx_byte_count(rx_byte_count),
        .addr_filter_enable(addr_filter_enable), .filter_pass(filter_pass),
        .frame_complete(frame_complete), .ack_frame_rx(ack_frame_rx),
        .power_mode(power_mode), .analog_reg_enable(analog_reg_enable),
        .digital_reg_enable(digital_reg_enable), .radio_irq_pending(radio_irq_pending)
    );

    always #2 clk_sys = ~clk_sys;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check_reg(input string nm, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            mismatches++;
        end
    endtask

    task automatic check_bit(input string nm, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %b seen %b", nm, exp, got);
            mismatches++;
        end
    endtask

    // The request is held until pready is seen high; the watchdog ends a wait on a dead slave.
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] v);
        logic [7:0] rd;
        logic       er;
        apb(1'b1, idx, v, rd, er);
    endtask

    task automatic rd_chk(input string nm, input logic [15:0] idx, input logic [7:0] exp);
        logic [7:0] rd;
        logic       er;
        apb(1'b0, idx, 8'h00, rd, er);
        check_reg(nm, exp, rd);
    endtask

    task automatic pulse_ev(input logic [2:0] m);
        @(posedge clk_sys);
        {ack_frame_rx, frame_complete, filter_pass} <= m;
        @(posedge clk_sys);
        {ack_frame_rx, frame_complete, filter_pass} <= 3'b000;
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        give_verdict();
    end

    initial begin
        clk_sys = 1'b0; reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; tx_active_in = 1'b0; sfd_in = 1'b0; cca_in = 1'b0;
        rx_byte_count = 8'h00; addr_filter_enable = 1'b0; filter_pass = 1'b0;
        frame_complete = 1'b0; ack_frame_rx = 1'b0; power_mode = 2'h0;
        mismatches = 0; comparisons = 0; seed = 32'hd10f115c;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        check_bit("analog_reg_enable", 1'b0, analog_reg_enable);
        check_bit("digital_reg_enable", 1'b1, digital_reg_enable);
        rd_chk("chip_revision", rsi_pkg::IDX_REVISION, REV_CODE);
        rd_chk("part_identification", rsi_pkg::IDX_PART_ID, PID_CODE);
        rd_chk("irq_source_config", rsi_pkg::IDX_IRQ_SRC, 8'h00);
        rd_chk("io_config_zero", rsi_pkg::IDX_IO_CFG0, 8'h40);
        rd_chk("radio_power_ctrl", rsi_pkg::IDX_PWR_CTRL, 8'h0b);
        rd_chk("radio_irq_flags", rsi_pkg::IDX_IRQ_FLAGS, 8'h00);
        // Writes to read-only places must be dropped silently.
        wr(rsi_pkg::IDX_PART_ID, 8'hff);
        wr(rsi_pkg::IDX_REVISION, 8'h00);
        rd_chk("part_identification", rsi_pkg::IDX_PART_ID, PID_CODE);
        rd_chk("chip_revision", rsi_pkg::IDX_REVISION, REV_CODE);
        apb(1'b0, 16'hdf63, 8'h00, d, e);
        check_bit("unmapped_error", 1'b1, e);
        check_reg("unmapped_data", 8'h00, d);
        wr(rsi_pkg::IDX_IRQ_SRC, 8'hfe);
        rd_chk("irq_source_config", rsi_pkg::IDX_IRQ_SRC, 8'h00);
        wr(rsi_pkg::IDX_IO_CFG0, 8'hff);
        rd_chk("io_config_zero", rsi_pkg::IDX_IO_CFG0, 8'h7f);
        // Many counts sit exactly on the level, the boundary where the flag must stay low.
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            m_lvl = r[6:0];
            m_cnt = (r[15:14] == 2'b00) ? 0 : (r[11] ? r[23:16] : m_lvl);
            wr(rsi_pkg::IDX_IO_CFG0, {1'b0, r[6:0]});
            @(posedge clk_sys);
            tx_active_in  <= r[8];
            sfd_in        <= r[9];
            cca_in        <= r[10];
            rx_byte_count <= m_cnt[7:0];
            repeat (6) @(posedge clk_sys);
            rd_chk("radio_status", rsi_pkg::IDX_STATUS,
                   {3'b000, r[8], m_cnt != 0, m_cnt > m_lvl, r[9], r[10]});
        end
        wr(rsi_pkg::IDX_IO_CFG0, 8'h05);
        @(posedge clk_sys);
        {tx_active_in, sfd_in, cca_in} <= 3'b000;
        addr_filter_enable <= 1'b1;
        rx_byte_count      <= 8'h10;
        repeat (6) @(posedge clk_sys);
        rd_chk("radio_status", rsi_pkg::IDX_STATUS, 8'h08);
        pulse_ev(3'b001);
        rd_chk("radio_status", rsi_pkg::IDX_STATUS, 8'h0c);
        @(posedge clk_sys);
        rx_byte_count      <= 8'h00;
        addr_filter_enable <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rx_byte_count <= 8'h02;
        pulse_ev(3'b010);
        rd_chk("radio_status", rsi_pkg::IDX_STATUS, 8'h0c);
        wr(rsi_pkg::IDX_IRQ_SRC, 8'h00);
        pulse_ev(3'b100);
        repeat (2) @(posedge clk_sys);
        check_bit("radio_irq_pending", 1'b0, radio_irq_pending);
        rd_chk("radio_irq_flags", rsi_pkg::IDX_IRQ_FLAGS, 8'h00);
        wr(rsi_pkg::IDX_IRQ_SRC, 8'h01);
        pulse_ev(3'b100);
        repeat (2) @(posedge clk_sys);
        check_bit("radio_irq_pending", 1'b1, radio_irq_pending);
        rd_chk("radio_irq_flags", rsi_pkg::IDX_IRQ_FLAGS, 8'h02);
        wr(rsi_pkg::IDX_IRQ_FLAGS, 8'h02);
        rd_chk("radio_irq_flags", rsi_pkg::IDX_IRQ_FLAGS, 8'h00);
        wr(rsi_pkg::IDX_PWR_CTRL, 8'h08);
        repeat (2) @(posedge clk_sys);
        check_bit("analog_reg_enable", 1'b0, analog_reg_enable);
        // Shortest delay setting: one unit of 250 cycles, plus a few cycles of pipeline.
        wr(rsi_pkg::IDX_PWR_CTRL, 8'h00);
        n = 0;
        while (analog_reg_enable !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        check_bit("powerup_delay", 1'b1, n >= 250 && n <= 260);
        rd_chk("radio_power_ctrl", rsi_pkg::IDX_PWR_CTRL, 8'h04);
        rd_chk("radio_irq_flags", rsi_pkg::IDX_IRQ_FLAGS, 8'h01);
        wr(rsi_pkg::IDX_PWR_CTRL, 8'h08);
        repeat (2) @(posedge clk_sys);
        check_bit("analog_reg_enable", 1'b0, analog_reg_enable);
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_sys);
            power_mode <= m[1:0];
            repeat (3) @(posedge clk_sys);
            check_bit("digital_reg_enable", m < 2, digital_reg_enable);
        end
        rd_chk("io_config_zero", rsi_pkg::IDX_IO_CFG0, 8'h05);
        rd_chk("irq_source_config", rsi_pkg::IDX_IRQ_SRC, 8'h01);
        @(posedge clk_sys);
        power_mode <= 2'h0;
        reset_n    <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd_chk("io_config_zero", rsi_pkg::IDX_IO_CFG0, 8'h40);
        give_verdict();
    end
endmodule // test_radio_status_id_regs
